/* design/dew_map.svh */
// Register map, field positions, key values and timing counts of the write control.
`ifndef DEW_MAP_SVH
`define DEW_MAP_SVH

// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define DEW_OFF_CONTROL 8'h00
`define DEW_OFF_KEY     8'h04
`define DEW_OFF_LOC_LO  8'h08
`define DEW_OFF_LOC_HI  8'h0C
`define DEW_OFF_DATA    8'h10
`define DEW_OFF_STATUS  8'h14

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define DEW_BIT_READ_GO   0
`define DEW_BIT_GO        1
`define DEW_BIT_PERMIT    2
`define DEW_BIT_FAULT     3
`define DEW_BIT_ERASE_SEL 4
`define DEW_BIT_REG_LO    6
`define DEW_BIT_REG_HI    7
`define DEW_BIT_DONE      0
`define DEW_BIT_BUSY      1

// ---------------------------------------------------------------
// Values
// ---------------------------------------------------------------
`define DEW_KEY_FIRST   8'h55
`define DEW_KEY_SECOND  8'hAA
`define DEW_ERASED_BYTE 8'hFF
`define DEW_REGION_EE   2'b00
`define DEW_DEPTH       1024
`define DEW_PROG_CYCLES 64
`define DEW_RESET_BYTE  8'h00

`endif

/* design/dew_pkg.sv */
// Types shared by the data EEPROM write control.
`default_nettype none
package dew_pkg;

  typedef enum logic [1:0] {
    DEW_IDLE    = 2'b00,
    DEW_ERASE   = 2'b01,
    DEW_PROGRAM = 2'b10
  } dew_state_type;

  typedef enum logic [1:0] {
    DEW_KEY_NONE  = 2'b00,
    DEW_KEY_HALF  = 2'b01,
    DEW_KEY_ARMED = 2'b10
  } dew_key_type;

endpackage

`default_nettype wire

/* design/dew_ctrl.sv */
// Data EEPROM write control with APB register access and its own cell array.
`timescale 1ns/1ps
`default_nettype none
`include "dew_map.svh"

module dew_ctrl #(
  parameter int PROG_CYCLES = `DEW_PROG_CYCLES
) (
  // Clock, resets and enable
  input  wire  logic        clock,
  input  wire  logic        resetn,
  input  wire  logic        porn,
  input  wire  logic        clock_enable,
  // APB slave
  input  wire  logic        psel,
  input  wire  logic        penable,
  input  wire  logic        pwrite,
  input  wire  logic [7:0]  paddr,
  input  wire  logic [31:0] pwdata,
  output logic       [31:0] prdata,
  output logic              pready,
  output logic              pslverr,
  // Protection and power-up inputs
  input  wire  logic        powerup_hold,
  input  wire  logic        write_protect,
  input  wire  logic        code_protect,
  // Status outputs
  output logic              write_busy,
  output logic              memory_done
);

  localparam int ERASE_CYCLES = PROG_CYCLES / 2;

  // ---------------------------------------------------------------
  // Storage and control state
  // ---------------------------------------------------------------
  logic [7:0]             cells [`DEW_DEPTH];
  dew_pkg::dew_state_type state;
  dew_pkg::dew_key_type   key_state;
  logic [15:0]            timer;
  logic [1:0]             region;
  logic                   erase_sel;
  logic                   fault;
  logic                   permit;
  logic                   go;
  logic                   read_go;
  logic                   pending_mark;
  logic [7:0]             location_low;
  logic [1:0]             location_high;
  logic [7:0]             data_holding;

  logic                   setup_phase;
  logic                   wr_fire;
  logic                   busy;
  logic [9:0]             location;
  logic                   ctrl_wr;
  logic                   go_req;
  logic                   go_ok;
  logic                   go_bad;
  logic                   interrupted;
  logic                   finish;
  logic                   mapped;
  logic [31:0]            next_prdata;

  assign setup_phase = psel & penable & ~pready;
  assign wr_fire     = psel & penable & pready & pwrite & clock_enable;
  assign busy        = (state != dew_pkg::DEW_IDLE);
  assign location    = {location_high, location_low};
  assign ctrl_wr     = wr_fire & (paddr == `DEW_OFF_CONTROL) & ~busy;
  assign go_req      = ctrl_wr & pwdata[`DEW_BIT_GO];
  // Permit must already be set; the written permit bit is not looked at.
  assign go_ok = go_req & permit & (key_state == dew_pkg::DEW_KEY_ARMED)
               & ~powerup_hold
               & (pwdata[`DEW_BIT_REG_HI:`DEW_BIT_REG_LO] == `DEW_REGION_EE)
               & ~write_protect & ~code_protect
               & (int'(location) < `DEW_DEPTH);
  // Only the EEPROM region is backed here, so any other region is a mismatch.
  assign go_bad      = go_req & ~go_ok & permit & (key_state == dew_pkg::DEW_KEY_ARMED)
                     & ~powerup_hold;
  assign interrupted = pending_mark & ~busy & ~go;
  assign finish      = (state == dew_pkg::DEW_PROGRAM) & (timer == 16'h0000);

  // ---------------------------------------------------------------
  // APB slave
  // ---------------------------------------------------------------
  always_comb begin
    next_prdata = 32'h0000_0000;
    mapped      = 1'b1;
    unique case (paddr)
      `DEW_OFF_CONTROL: next_prdata[7:0] = {region, 1'b0, erase_sel, fault, permit, go, read_go};
      `DEW_OFF_KEY:     next_prdata[7:0] = 8'h00;
      `DEW_OFF_LOC_LO:  next_prdata[7:0] = location_low;
      `DEW_OFF_LOC_HI:  next_prdata[1:0] = location_high;
      `DEW_OFF_DATA:    next_prdata[7:0] = data_holding;
      `DEW_OFF_STATUS:  next_prdata[1:0] = {busy, memory_done};
      default:          mapped = 1'b0;
    endcase
  end

  always_ff @(posedge clock or negedge resetn or negedge porn) begin
    if (!resetn || !porn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (clock_enable) begin
      pready  <= setup_phase;
      if (setup_phase) begin
        prdata  <= pwrite ? 32'h0000_0000 : next_prdata;
        pslverr <= ~mapped;
      end
    end
  end

  // ---------------------------------------------------------------
  // Unlock key sequencer
  // ---------------------------------------------------------------
  // Any other register write between the key bytes and go breaks the sequence.
  always_ff @(posedge clock or negedge resetn or negedge porn) begin
    if (!resetn || !porn) begin
      key_state <= dew_pkg::DEW_KEY_NONE;
    end else if (wr_fire) begin
      if (paddr == `DEW_OFF_KEY && pwdata[7:0] == `DEW_KEY_FIRST) begin
        key_state <= dew_pkg::DEW_KEY_HALF;
      end else if (paddr == `DEW_OFF_KEY && pwdata[7:0] == `DEW_KEY_SECOND
                   && key_state == dew_pkg::DEW_KEY_HALF) begin
        key_state <= dew_pkg::DEW_KEY_ARMED;
      end else begin
        key_state <= dew_pkg::DEW_KEY_NONE;
      end
    end
  end

  // ---------------------------------------------------------------
  // Control register
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge resetn or negedge porn) begin
    if (!resetn || !porn) begin
      region    <= 2'b00;
      erase_sel <= 1'b0;
      permit    <= 1'b0;
    end else if (ctrl_wr) begin
      region    <= pwdata[`DEW_BIT_REG_HI:`DEW_BIT_REG_LO];
      erase_sel <= pwdata[`DEW_BIT_ERASE_SEL];
      permit    <= pwdata[`DEW_BIT_PERMIT];
    end
  end

  // Go is set only by a good request and cleared only by completion.
  always_ff @(posedge clock or negedge resetn or negedge porn) begin
    if (!resetn || !porn) begin
      go <= 1'b0;
    end else if (clock_enable) begin
      if (go_ok) begin
        go <= 1'b1;
      end else if (finish) begin
        go <= 1'b0;
      end
    end
  end

  // Fault survives a plain reset so that an interrupted write can be reported.
  always_ff @(posedge clock or negedge porn) begin
    if (!porn) begin
      fault <= 1'b0;
    end else if (clock_enable) begin
      if (go_bad || interrupted) begin
        fault <= 1'b1;
      end else if (ctrl_wr) begin
        fault <= pwdata[`DEW_BIT_FAULT];
      end
    end
  end

  always_ff @(posedge clock or negedge porn) begin
    if (!porn) begin
      pending_mark <= 1'b0;
    end else if (clock_enable) begin
      if (go_ok) begin
        pending_mark <= 1'b1;
      end else if (finish || interrupted) begin
        pending_mark <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Write sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge resetn or negedge porn) begin
    if (!resetn || !porn) begin
      state <= dew_pkg::DEW_IDLE;
      timer <= 16'h0000;
    end else if (clock_enable) begin
      unique case (state)
        dew_pkg::DEW_IDLE: begin
          if (go_ok) begin
            state <= dew_pkg::DEW_ERASE;
            timer <= 16'(ERASE_CYCLES - 1);
          end
        end
        dew_pkg::DEW_ERASE: begin
          if (timer == 16'h0000) begin
            state <= dew_pkg::DEW_PROGRAM;
            timer <= 16'(PROG_CYCLES - ERASE_CYCLES - 1);
          end else begin
            timer <= timer - 16'h0001;
          end
        end
        dew_pkg::DEW_PROGRAM: begin
          if (timer == 16'h0000) begin
            state <= dew_pkg::DEW_IDLE;
          end else begin
            timer <= timer - 16'h0001;
          end
        end
        default: begin
          state <= dew_pkg::DEW_IDLE;
        end
      endcase
    end
  end

  // The array has no reset; cells keep their contents like the real memory.
  always_ff @(posedge clock) begin
    if (clock_enable) begin
      if (state == dew_pkg::DEW_ERASE && timer == 16'h0000) begin
        cells[location] <= `DEW_ERASED_BYTE;
      end else if (finish) begin
        cells[location] <= data_holding;
      end
    end
  end

  // ---------------------------------------------------------------
  // Location, data and read
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge resetn or negedge porn) begin
    if (!resetn || !porn) begin
      location_low  <= `DEW_RESET_BYTE;
      location_high <= 2'b00;
    end else if (wr_fire && !busy) begin
      if (paddr == `DEW_OFF_LOC_LO) begin
        location_low <= pwdata[7:0];
      end
      if (paddr == `DEW_OFF_LOC_HI) begin
        location_high <= pwdata[1:0];
      end
    end
  end

  always_ff @(posedge clock or negedge resetn or negedge porn) begin
    if (!resetn || !porn) begin
      read_go <= 1'b0;
    end else if (clock_enable) begin
      read_go <= ctrl_wr & pwdata[`DEW_BIT_READ_GO] & ~go_req;
    end
  end

  // Only EEPROM is backed; other regions and code-protected parts read as zero.
  always_ff @(posedge clock or negedge resetn or negedge porn) begin
    if (!resetn || !porn) begin
      data_holding <= `DEW_RESET_BYTE;
    end else if (clock_enable) begin
      if (read_go) begin
        data_holding <= (region == `DEW_REGION_EE && !code_protect)
                      ? cells[location] : 8'h00;
      end else if (wr_fire && !busy && paddr == `DEW_OFF_DATA) begin
        data_holding <= pwdata[7:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // Done flag and busy output
  // ---------------------------------------------------------------
  // A completion in the same cycle as a software clear wins.
  always_ff @(posedge clock or negedge resetn or negedge porn) begin
    if (!resetn || !porn) begin
      memory_done <= 1'b0;
    end else if (clock_enable) begin
      if (finish) begin
        memory_done <= 1'b1;
      end else if (wr_fire && paddr == `DEW_OFF_STATUS && pwdata[`DEW_BIT_DONE]) begin
        memory_done <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock or negedge resetn or negedge porn) begin
    if (!resetn || !porn) begin
      write_busy <= 1'b0;
    end else if (clock_enable) begin
      write_busy <= go_ok | (busy & ~finish);
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  chk_go_needs_key: assert property (@(posedge clock) disable iff (!resetn || !porn)
    $rose(go) |-> $past(key_state) == dew_pkg::DEW_KEY_ARMED)
    else $error("Write started without unlock key");

  chk_go_needs_permit: assert property (@(posedge clock) disable iff (!resetn || !porn)
    $rose(go) |-> $past(permit))
    else $error("Write started without prior permit");

  chk_permit_kept: assert property (@(posedge clock) disable iff (!resetn || !porn)
    finish && permit && clock_enable |=> permit)
    else $error("Permit cleared by write completion");

  chk_loc_frozen: assert property (@(posedge clock) disable iff (!resetn || !porn)
    busy && clock_enable |=> $stable(location) && $stable(data_holding))
    else $error("Location or data changed during write");

  chk_done_on_end: assert property (@(posedge clock) disable iff (!resetn || !porn)
    finish && clock_enable |=> memory_done && !go)
    else $error("Completion did not set done and clear go");

  chk_hold_blocks: assert property (@(posedge clock) disable iff (!resetn || !porn)
    powerup_hold |=> !$rose(go))
    else $error("Write started during power-up hold");

  chk_bad_go_fault: assert property (@(posedge clock) disable iff (!resetn || !porn)
    go_bad && clock_enable |=> fault && !go)
    else $error("Bad go did not raise fault");

  chk_write_length: assert property (@(posedge clock) disable iff (!resetn || !porn)
    $rose(go) && clock_enable |-> go[*8])
    else $error("Write ended too early");

  chk_read_next: assert property (@(posedge clock) disable iff (!resetn || !porn)
    read_go && clock_enable && region == `DEW_REGION_EE && !code_protect
    |=> !read_go && data_holding == $past(cells[location]))
    else $error("Read data not loaded next cycle");

  chk_key_reads_zero: assert property (@(posedge clock) disable iff (!resetn || !porn)
    setup_phase && !pwrite && paddr == `DEW_OFF_KEY && clock_enable |=> prdata == 32'h0)
    else $error("Key port read not zero");

  cov_write_done: cover property (@(posedge clock) disable iff (!resetn) finish);
  cov_bad_go: cover property (@(posedge clock) disable iff (!resetn) go_bad);
  cov_read: cover property (@(posedge clock) disable iff (!resetn) read_go);

endmodule

`default_nettype wire

/* testbench/test_data_eeprom_write_control.sv */
// Self-checking testbench of the data EEPROM write control over APB.
`timescale 1ns/1ps
`default_nettype none
`include "dew_map.svh"

module test_data_eeprom_write_control;
  // Shortened programming time keeps the run brief; expectations follow it.
  localparam int PROG = 40;

  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic        clock;
  logic        resetn;
  logic        porn;
  logic        clock_enable;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        powerup_hold;
  logic        write_protect;
  logic        code_protect;
  logic        write_busy;
  logic        memory_done;
  logic [31:0] rdata;
  logic        slverr;
  logic [7:0]  ctl;
  int          n_errors;
  int          check_count;

  dew_ctrl #(.PROG_CYCLES(PROG)) dew_ctrl_inst (
    .clock         (clock),
    .resetn        (resetn),
    .porn          (porn),
    .clock_enable  (clock_enable),
    .psel          (psel),
    .penable       (penable),
    .pwrite        (pwrite),
    .paddr         (paddr),
    .pwdata        (pwdata),
    .prdata        (prdata),
    .pready        (pready),
    .pslverr       (pslverr),
    .powerup_hold  (powerup_hold),
    .write_protect (write_protect),
    .code_protect  (code_protect),
    .write_busy    (write_busy),
    .memory_done   (memory_done)
  );

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic end_of_test;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  // The request is held until pready is seen high at a rising edge.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      chk("pready", 32'h0000_0001, {31'h0000_0000, pready});
      end_of_test();
    end else begin
      rdata   = prdata;
      slverr  = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string name);
    apb(1'b0, a, 32'h0000_0000);
    chk(name, exp, rdata);
  endtask

  task automatic key_go(input logic [7:0] c);
    apb(1'b1, `DEW_OFF_KEY, {24'h00_0000, `DEW_KEY_FIRST});
    apb(1'b1, `DEW_OFF_KEY, {24'h00_0000, `DEW_KEY_SECOND});
    apb(1'b1, `DEW_OFF_CONTROL, {24'h00_0000, c});
  endtask

  task automatic set_loc(input logic [9:0] a);
    apb(1'b1, `DEW_OFF_LOC_LO, {24'h00_0000, a[7:0]});
    apb(1'b1, `DEW_OFF_LOC_HI, {30'h0000_0000, a[9:8]});
  endtask

  task automatic wait_done;
    int n;
    n = 0;
    while (memory_done !== 1'b1 && n < 4 * PROG) begin
      @(posedge clock);
      n++;
    end
    if (memory_done !== 1'b1) begin
      chk("memory_done", 32'h0000_0001, 32'h0000_0000);
      end_of_test();
    end
  endtask

  task automatic write_byte(input logic [9:0] a, input logic [7:0] d);
    set_loc(a);
    apb(1'b1, `DEW_OFF_DATA, {24'h00_0000, d});
    key_go(8'h06);
    wait_done();
    apb(1'b1, `DEW_OFF_STATUS, 32'h0000_0001);
  endtask

  task automatic read_byte(input logic [9:0] a, input logic [7:0] d);
    set_loc(a);
    apb(1'b1, `DEW_OFF_CONTROL, 32'h0000_0005);
    rd_chk(`DEW_OFF_DATA, {24'h00_0000, d}, "data_holding");
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    n_errors = 0;
    check_count = 0;
    resetn = 1'b0;
    porn = 1'b0;
    clock_enable = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    powerup_hold = 1'b0;
    write_protect = 1'b0;
    code_protect = 1'b0;
    repeat (4) @(posedge clock);
    resetn <= 1'b1;
    porn <= 1'b1;
    rd_chk(`DEW_OFF_CONTROL, 32'h0000_0000, "control reset");
    rd_chk(`DEW_OFF_STATUS, 32'h0000_0000, "status reset");
    apb(1'b1, 8'h18, 32'h0000_00FF);
    chk("unmapped write error", 32'h0000_0001, {31'h0000_0000, slverr});
    apb(1'b0, 8'h18, 32'h0000_0000);
    chk("unmapped read error", 32'h0000_0001, {31'h0000_0000, slverr});
    // Permit and go in one write must not start anything.
    key_go(8'h06);
    rd_chk(`DEW_OFF_STATUS, 32'h0000_0000, "status same write");
    rd_chk(`DEW_OFF_CONTROL, 32'h0000_0004, "control same write");
    apb(1'b1, `DEW_OFF_KEY, {24'h00_0000, `DEW_KEY_FIRST});
    rd_chk(`DEW_OFF_KEY, 32'h0000_0000, "key read");
    apb(1'b1, `DEW_OFF_CONTROL, 32'h0000_0006);
    rd_chk(`DEW_OFF_STATUS, 32'h0000_0000, "status half key");
    apb(1'b1, `DEW_OFF_KEY, {24'h00_0000, `DEW_KEY_FIRST});
    apb(1'b1, `DEW_OFF_DATA, 32'h0000_005A);
    apb(1'b1, `DEW_OFF_KEY, {24'h00_0000, `DEW_KEY_SECOND});
    apb(1'b1, `DEW_OFF_CONTROL, 32'h0000_0006);
    rd_chk(`DEW_OFF_STATUS, 32'h0000_0000, "status broken key");
    // A write with interference on the data, location low and control registers while it runs.
    set_loc(10'h305);
    apb(1'b1, `DEW_OFF_DATA, 32'h0000_00A5);
    key_go(8'h06);
    rd_chk(`DEW_OFF_STATUS, 32'h0000_0002, "status busy");
    chk("write_busy", 32'h0000_0001, {31'h0000_0000, write_busy});
    // A low clock enable must hold the write where it is.
    clock_enable <= 1'b0;
    repeat (2 * PROG) @(posedge clock);
    chk("frozen busy", 32'h0000_0001, {31'h0000_0000, write_busy});
    chk("frozen done", 32'h0000_0000, {31'h0000_0000, memory_done});
    clock_enable <= 1'b1;
    apb(1'b1, `DEW_OFF_DATA, 32'h0000_0011);
    apb(1'b1, `DEW_OFF_LOC_LO, 32'h0000_0000);
    apb(1'b1, `DEW_OFF_CONTROL, 32'h0000_0000);
    rd_chk(`DEW_OFF_CONTROL, 32'h0000_0006, "control busy");
    wait_done();
    rd_chk(`DEW_OFF_CONTROL, 32'h0000_0004, "control done");
    repeat (10) @(posedge clock);
    rd_chk(`DEW_OFF_STATUS, 32'h0000_0001, "done held");
    apb(1'b1, `DEW_OFF_STATUS, 32'h0000_0001);
    rd_chk(`DEW_OFF_STATUS, 32'h0000_0000, "done cleared");
    rd_chk(`DEW_OFF_LOC_LO, 32'h0000_0005, "location_low");
    rd_chk(`DEW_OFF_LOC_HI, 32'h0000_0003, "location_high");
    read_byte(10'h305, 8'hA5);
    write_byte(10'h3FF, `DEW_ERASED_BYTE);
    write_byte(10'h000, 8'h3C);
    read_byte(10'h3FF, `DEW_ERASED_BYTE);
    read_byte(10'h000, 8'h3C);
    read_byte(10'h305, 8'hA5);
    rd_chk(`DEW_OFF_CONTROL, 32'h0000_0004, "read go cleared");
    // Protected, code protected and region mismatch each drop go and fault.
    for (int i = 0; i < 3; i++) begin
      write_protect <= (i == 0);
      code_protect <= (i == 1);
      ctl = (i == 2) ? 8'h86 : 8'h06;
      key_go(ctl);
      rd_chk(`DEW_OFF_CONTROL, {24'h00_0000, ctl ^ 8'h0A}, "control fault");
      rd_chk(`DEW_OFF_STATUS, 32'h0000_0000, "status fault");
      if (i == 1) begin
        read_byte(10'h305, 8'h00);
      end
      apb(1'b1, `DEW_OFF_CONTROL, 32'h0000_0004);
      rd_chk(`DEW_OFF_CONTROL, 32'h0000_0004, "fault cleared");
    end
    write_protect <= 1'b0;
    code_protect <= 1'b0;
    apb(1'b1, `DEW_OFF_CONTROL, 32'h0000_000C);
    repeat (5) @(posedge clock);
    rd_chk(`DEW_OFF_CONTROL, 32'h0000_000C, "fault set by software");
    apb(1'b1, `DEW_OFF_CONTROL, 32'h0000_0014);
    rd_chk(`DEW_OFF_CONTROL, 32'h0000_0014, "erase select");
    apb(1'b1, `DEW_OFF_CONTROL, 32'h0000_0004);
    powerup_hold <= 1'b1;
    key_go(8'h06);
    rd_chk(`DEW_OFF_STATUS, 32'h0000_0000, "status hold");
    rd_chk(`DEW_OFF_CONTROL, 32'h0000_0004, "control hold");
    powerup_hold <= 1'b0;
    // A general reset in mid-write leaves the fault flag behind.
    key_go(8'h06);
    repeat (5) @(posedge clock);
    resetn <= 1'b0;
    repeat (2) @(posedge clock);
    resetn <= 1'b1;
    apb(1'b0, `DEW_OFF_CONTROL, 32'h0000_0000);
    chk("fault after reset", 32'h0000_0008, rdata & 32'h0000_0008);
    @(posedge clock);
    porn <= 1'b0;
    repeat (2) @(posedge clock);
    porn <= 1'b1;
    rd_chk(`DEW_OFF_CONTROL, 32'h0000_0000, "control power on");
    end_of_test();
  end
endmodule

`default_nettype wire
